// ==== block_transfer_sequencer.sv ====
`timescale 1ns/10ps
`default_nettype none
module block_transfer_sequencer #(
  parameter int WORD_W = 36
) (
  input  wire logic                                  mclk,
  input  wire logic                                  rst_b,
  input  wire logic                                  ce,
  input  wire logic                                  masterClear,
  input  wire logic                                  start,
  input  wire logic [WORD_W-1:0]                     accWord,
  input  wire logic [WORD_W/2-1:0]                   effAddr,
  output block_transfer_pkg::mem_cmd_s               memCmd,
  input  wire logic                                  memAck,
  input  wire logic [WORD_W-1:0]                     memRdata,
  output logic                                       intrStrobe,
  input  wire logic                                  intrPending,
  output logic                                       pcIncrement,
  output logic                                       countInhibit,
  output logic                                       transferDoneLevel,
  output logic                                       lastIterationLevel,
  output logic                                       accStore,
  output logic [WORD_W-1:0]                          accStoreData,
  output logic                                       finished,
  output logic                                       busy
);

  localparam int HALF_W = WORD_W / 2;

  if (WORD_W != block_transfer_pkg::WORD_W || (WORD_W % 2) != 0) begin : g_width_check
    $error("block_transfer_sequencer: WORD_W must match the package word width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state and registers

  block_transfer_pkg::seq_state_e state_q;
  block_transfer_pkg::seq_state_e state_d;

  logic [WORD_W-1:0] arithmeticReg_q;
  logic [WORD_W-1:0] memoryBufferReg_q;
  logic [WORD_W-1:0] quotientReg_q;
  logic [HALF_W-1:0] memoryAddrReg_q;
  logic              transferDone_q;
  logic              lastIteration_q;

  logic [WORD_W-1:0] differenceWord;
  logic [WORD_W-1:0] incrementedWord;
  logic              quotientSignBit;
  logic              memTaken;

  assign quotientSignBit = quotientReg_q[WORD_W-1];
  // ack only counts while a request stands, so a late ack cannot leak into a later step
  assign memTaken        = memAck && memCmd.req;

  word_subtractor #(
    .WORD_W     (WORD_W)
  ) u_subtractor (
    .minuend    (arithmeticReg_q),
    .subtrahend (memoryBufferReg_q),
    .difference (differenceWord)
  );

  half_incrementer #(
    .HALF_W  (HALF_W)
  ) u_incrementer (
    .wordIn  (arithmeticReg_q),
    .wordOut (incrementedWord)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequence

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      block_transfer_pkg::ST_IDLE:
      begin
        if (start)
        begin
          state_d = block_transfer_pkg::ST_FETCH_RESUME;
        end
      end
      block_transfer_pkg::ST_FETCH_RESUME:
      begin
        state_d = block_transfer_pkg::ST_READ_SOURCE;
      end
      block_transfer_pkg::ST_READ_SOURCE:
      begin
        if (memTaken)
        begin
          state_d = block_transfer_pkg::ST_EXEC_ZERO;
        end
      end
      block_transfer_pkg::ST_EXEC_ZERO:
      begin
        state_d = block_transfer_pkg::ST_EXEC_ONE;
      end
      block_transfer_pkg::ST_EXEC_ONE:
      begin
        state_d = block_transfer_pkg::ST_EXEC_THREE;
      end
      block_transfer_pkg::ST_EXEC_THREE:
      begin
        state_d = block_transfer_pkg::ST_COPY_FIRST;
      end
      block_transfer_pkg::ST_COPY_FIRST:
      begin
        state_d = block_transfer_pkg::ST_WRITE_WAIT;
      end
      block_transfer_pkg::ST_WRITE_WAIT:
      begin
        if (memTaken)
        begin
          state_d = block_transfer_pkg::ST_COPY_RETURN;
        end
      end
      block_transfer_pkg::ST_COPY_RETURN:
      begin
        state_d = block_transfer_pkg::ST_CLEAR_LEFT;
      end
      block_transfer_pkg::ST_CLEAR_LEFT:
      begin
        state_d = block_transfer_pkg::ST_SUBTRACT;
      end
      block_transfer_pkg::ST_SUBTRACT:
      begin
        state_d = block_transfer_pkg::ST_PARK;
      end
      block_transfer_pkg::ST_PARK:
      begin
        state_d = block_transfer_pkg::ST_DIFFERENCE;
      end
      block_transfer_pkg::ST_DIFFERENCE:
      begin
        state_d = block_transfer_pkg::ST_INCREMENT;
      end
      block_transfer_pkg::ST_INCREMENT:
      begin
        state_d = block_transfer_pkg::ST_TEST;
      end
      block_transfer_pkg::ST_TEST:
      begin
        if (!quotientSignBit || transferDone_q)
        begin
          state_d = block_transfer_pkg::ST_EXEC_FINAL;
        end
        else
        begin
          state_d = block_transfer_pkg::ST_LOOP;
        end
      end
      block_transfer_pkg::ST_LOOP:
      begin
        state_d = block_transfer_pkg::ST_FETCH_RESUME;
      end
      block_transfer_pkg::ST_EXEC_FINAL:
      begin
        state_d = block_transfer_pkg::ST_IDLE;
      end
      default:
      begin
        state_d = block_transfer_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      state_q <= block_transfer_pkg::ST_IDLE;
    end
    else if (ce)
    begin
      if (masterClear)
      begin
        state_q <= block_transfer_pkg::ST_IDLE;
      end
      else
      begin
        state_q <= state_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory address register

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      memoryAddrReg_q <= block_transfer_pkg::HALF_RESET;
    end
    else if (ce)
    begin
      case (state_q)
        block_transfer_pkg::ST_FETCH_RESUME:
        begin
          memoryAddrReg_q <= memoryBufferReg_q[WORD_W-1:HALF_W];
        end
        block_transfer_pkg::ST_EXEC_ONE:
        begin
          memoryAddrReg_q <= block_transfer_pkg::HALF_RESET;
        end
        block_transfer_pkg::ST_EXEC_THREE:
        begin
          memoryAddrReg_q <= memoryBufferReg_q[HALF_W-1:0];
        end
        default:
        begin
          memoryAddrReg_q <= memoryAddrReg_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory buffer register

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      memoryBufferReg_q <= block_transfer_pkg::WORD_RESET;
    end
    else if (ce)
    begin
      case (state_q)
        block_transfer_pkg::ST_IDLE:
        begin
          if (start)
          begin
            // the pair stands as if just read from the accumulator
            memoryBufferReg_q <= accWord;
          end
        end
        block_transfer_pkg::ST_FETCH_RESUME:
        begin
          memoryBufferReg_q <= {block_transfer_pkg::HALF_RESET, arithmeticReg_q[HALF_W-1:0]};
        end
        block_transfer_pkg::ST_EXEC_ZERO:
        begin
          memoryBufferReg_q <= arithmeticReg_q;
        end
        block_transfer_pkg::ST_EXEC_ONE:
        begin
          memoryBufferReg_q <= {memoryBufferReg_q[HALF_W-1:0],
                                memoryBufferReg_q[WORD_W-1:HALF_W]};
        end
        block_transfer_pkg::ST_COPY_FIRST:
        begin
          memoryBufferReg_q <= quotientReg_q;
        end
        block_transfer_pkg::ST_WRITE_WAIT:
        begin
          if (memTaken)
          begin
            memoryBufferReg_q <= quotientReg_q;
          end
        end
        block_transfer_pkg::ST_COPY_RETURN:
        begin
          memoryBufferReg_q <= arithmeticReg_q;
        end
        block_transfer_pkg::ST_PARK:
        begin
          memoryBufferReg_q <= quotientReg_q;
        end
        block_transfer_pkg::ST_DIFFERENCE:
        begin
          memoryBufferReg_q <= arithmeticReg_q;
        end
        block_transfer_pkg::ST_INCREMENT:
        begin
          memoryBufferReg_q <= quotientReg_q;
        end
        block_transfer_pkg::ST_LOOP:
        begin
          memoryBufferReg_q <= arithmeticReg_q;
        end
        default:
        begin
          memoryBufferReg_q <= memoryBufferReg_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic register

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      arithmeticReg_q <= block_transfer_pkg::WORD_RESET;
    end
    else if (ce)
    begin
      case (state_q)
        block_transfer_pkg::ST_IDLE:
        begin
          if (start)
          begin
            arithmeticReg_q <= {block_transfer_pkg::HALF_RESET, effAddr};
          end
        end
        block_transfer_pkg::ST_FETCH_RESUME:
        begin
          arithmeticReg_q <= {memoryBufferReg_q[HALF_W-1:0],
                              memoryBufferReg_q[WORD_W-1:HALF_W]};
        end
        block_transfer_pkg::ST_EXEC_ZERO:
        begin
          arithmeticReg_q <= memoryBufferReg_q;
        end
        block_transfer_pkg::ST_COPY_RETURN:
        begin
          arithmeticReg_q <= memoryBufferReg_q;
        end
        block_transfer_pkg::ST_CLEAR_LEFT:
        begin
          arithmeticReg_q[WORD_W-1:HALF_W] <= block_transfer_pkg::HALF_RESET;
        end
        block_transfer_pkg::ST_SUBTRACT:
        begin
          // negative until the destination has reached the effective address
          arithmeticReg_q <= differenceWord;
        end
        block_transfer_pkg::ST_DIFFERENCE:
        begin
          arithmeticReg_q <= memoryBufferReg_q;
        end
        block_transfer_pkg::ST_INCREMENT:
        begin
          arithmeticReg_q <= incrementedWord;
        end
        block_transfer_pkg::ST_LOOP:
        begin
          arithmeticReg_q <= memoryBufferReg_q;
        end
        default:
        begin
          arithmeticReg_q <= arithmeticReg_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // quotient register

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      quotientReg_q <= block_transfer_pkg::WORD_RESET;
    end
    else if (ce)
    begin
      case (state_q)
        block_transfer_pkg::ST_READ_SOURCE:
        begin
          if (memTaken)
          begin
            quotientReg_q <= memRdata;
          end
        end
        block_transfer_pkg::ST_COPY_FIRST:
        begin
          quotientReg_q <= memoryBufferReg_q;
        end
        block_transfer_pkg::ST_PARK:
        begin
          quotientReg_q <= memoryBufferReg_q;
        end
        block_transfer_pkg::ST_INCREMENT:
        begin
          quotientReg_q <= memoryBufferReg_q;
        end
        default:
        begin
          quotientReg_q <= quotientReg_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control flip-flops

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      transferDone_q  <= 1'b0;
      lastIteration_q <= 1'b0;
    end
    else if (ce)
    begin
      if (masterClear || state_q == block_transfer_pkg::ST_FETCH_RESUME)
      begin
        transferDone_q  <= 1'b0;
        lastIteration_q <= 1'b0;
      end
      else if (state_q == block_transfer_pkg::ST_DIFFERENCE && intrPending)
      begin
        transferDone_q <= 1'b1;
      end
      else if (state_q == block_transfer_pkg::ST_TEST && !quotientSignBit)
      begin
        transferDone_q  <= 1'b1;
        lastIteration_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb
  begin
    memCmd       = '0;
    memCmd.addr  = memoryAddrReg_q;
    memCmd.wdata = memoryBufferReg_q;
    if (state_q == block_transfer_pkg::ST_READ_SOURCE)
    begin
      memCmd.req = 1'b1;
    end
    else if (state_q == block_transfer_pkg::ST_WRITE_WAIT)
    begin
      // held until memory acknowledges the write
      memCmd.req   = 1'b1;
      memCmd.write = 1'b1;
    end
  end

  assign intrStrobe         = state_q == block_transfer_pkg::ST_DIFFERENCE;
  assign pcIncrement        = state_q == block_transfer_pkg::ST_TEST && !quotientSignBit;
  assign busy               = state_q != block_transfer_pkg::ST_IDLE;
  assign countInhibit       = busy;
  assign transferDoneLevel  = transferDone_q;
  assign lastIterationLevel = lastIteration_q;
  assign finished           = state_q == block_transfer_pkg::ST_EXEC_FINAL;
  // an interrupt exit stores the incremented pair so a re-run resumes there
  assign accStore           = finished && !lastIteration_q;
  assign accStoreData       = arithmeticReg_q;

endmodule // block_transfer_sequencer
`default_nettype wire

// ==== block_transfer_pkg.sv ====
// Summary of operation
// - source address is the accumulator left half, destination the right half.
// - repeat fetch, store, increment until destination reaches or passes the effective address.
// - first fetch swaps accumulator halves, source goes to address register, source read.
// - first execute step exchanges buffer and arithmetic register.
// - step one clears address register, swaps buffer halves; step three loads destination.
// - first copy step exchanges buffer and quotient, then requests memory write.
// - on memory return copy quotient to buffer, then exchange buffer and arithmetic.
// - clear arithmetic left half, then subtract effective address from destination.
// - park effective address in quotient, restore pair, then move difference and pair.
// - move difference to quotient, effective address to buffer, increment both halves.
// - save effective address, move new addresses to buffer, re-enter fetch resume point.
// - sign bit 0 of the difference increments the program counter and ends.
// - normal program counting is suppressed throughout the whole transfer.
// - normal completion performs no store; processor continues with next instruction.
// - strobe the priority interrupt system at the difference step every iteration.
// - pending interrupt asserts the done level and skips the final exchange.
// - interrupt exit keeps last level low so incremented addresses are stored.
// - re-execution fetches the updated address pair and continues from there.
// - control flip-flops are cleared at each main sequence start and by master clear.
package block_transfer_pkg;

  localparam int WORD_W = 36;
  localparam int HALF_W = WORD_W / 2;

  localparam logic [WORD_W-1:0] WORD_RESET = 36'h0_0000_0000;
  localparam logic [HALF_W-1:0] HALF_RESET = 18'h0_0000;
  localparam logic [HALF_W-1:0] HALF_ONE   = 18'h0_0001;

  typedef enum logic [4:0] {
    ST_IDLE         = 5'b00000,
    ST_FETCH_RESUME = 5'b00001,
    ST_READ_SOURCE  = 5'b00010,
    ST_EXEC_ZERO    = 5'b00011,
    ST_EXEC_ONE     = 5'b00100,
    ST_EXEC_THREE   = 5'b00101,
    ST_COPY_FIRST   = 5'b00110,
    ST_WRITE_WAIT   = 5'b00111,
    ST_COPY_RETURN  = 5'b01000,
    ST_CLEAR_LEFT   = 5'b01001,
    ST_SUBTRACT     = 5'b01010,
    ST_PARK         = 5'b01011,
    ST_DIFFERENCE   = 5'b01100,
    ST_INCREMENT    = 5'b01101,
    ST_TEST         = 5'b01110,
    ST_LOOP         = 5'b01111,
    ST_EXEC_FINAL   = 5'b10000
  } seq_state_e;

  typedef struct packed {
    logic              req;
    logic              write;
    logic [HALF_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } mem_cmd_s;

endpackage

// ==== half_incrementer.sv ====
`timescale 1ns/10ps
`default_nettype none
module half_incrementer #(
  parameter int HALF_W = 18
) (
  input  wire logic [2*HALF_W-1:0] wordIn,
  output logic      [2*HALF_W-1:0] wordOut
);

  // each half wraps on its own; no carry crosses between the halves
  for (genvar h = 0; h < 2; h++) begin : g_half
    assign wordOut[h*HALF_W +: HALF_W] = wordIn[h*HALF_W +: HALF_W] + HALF_W'(1);
  end

endmodule // half_incrementer
`default_nettype wire

// ==== word_subtractor.sv ====
`timescale 1ns/10ps
`default_nettype none
module word_subtractor #(
  parameter int WORD_W = 36
) (
  input  wire logic [WORD_W-1:0] minuend,
  input  wire logic [WORD_W-1:0] subtrahend,
  output logic      [WORD_W-1:0] difference
);

  assign difference = minuend - subtrahend;

endmodule // word_subtractor
`default_nettype wire

// ==== block_transfer_sequencer_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module block_transfer_sequencer_checker #(
  parameter int WORD_W = 36
) (
  input wire logic                         mclk,
  input wire logic                         rst_b,
  input wire logic                         ce,
  input wire logic                         masterClear,
  input wire logic                         start,
  input wire logic [WORD_W-1:0]            accWord,
  input wire logic [WORD_W/2-1:0]          effAddr,
  input wire block_transfer_pkg::mem_cmd_s memCmd,
  input wire logic                         memAck,
  input wire logic [WORD_W-1:0]            memRdata,
  input wire logic                         intrStrobe,
  input wire logic                         intrPending,
  input wire logic                         pcIncrement,
  input wire logic                         countInhibit,
  input wire logic                         transferDoneLevel,
  input wire logic                         lastIterationLevel,
  input wire logic                         accStore,
  input wire logic [WORD_W-1:0]            accStoreData,
  input wire logic                         finished,
  input wire logic                         busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  AST_READ_SOURCE: assert property (start && ce && !busy && !masterClear |-> ##2
    memCmd.req && !memCmd.write && memCmd.addr == $past(accWord[WORD_W-1:WORD_W/2], 2))
    else $error("first read not at source address");
  AST_REQ_HOLD: assert property (memCmd.req && !memAck && !masterClear |=>
    memCmd.req && $stable(memCmd.addr) && $stable(memCmd.wdata))
    else $error("memory request changed before acknowledge");
  AST_ACK_DROP: assert property (memCmd.req && memAck && ce && !masterClear |=> !memCmd.req)
    else $error("request not dropped after acknowledge");
  AST_PC_NORMAL: assert property (pcIncrement && ce && !masterClear |=> finished && !accStore)
    else $error("normal completion did not end cleanly");
  AST_INHIBIT_BUSY: assert property (memCmd.req || intrStrobe || finished |-> countInhibit)
    else $error("count inhibit differs from busy");
  AST_FINISH_IDLE: assert property (finished && ce |=> !busy)
    else $error("still busy after final step");
  AST_INTR_THEN_END: assert property (intrStrobe && intrPending |-> ##3 finished)
    else $error("pending interrupt did not end transfer");
  AST_STORE_ON_IRQ: assert property (accStore |-> finished && !lastIterationLevel)
    else $error("address store outside interrupt exit");
  AST_MCLEAR: assert property (masterClear && ce |=>
    !busy && !transferDoneLevel && !lastIterationLevel)
    else $error("master clear left state set");
endmodule // block_transfer_sequencer_checker

bind block_transfer_sequencer block_transfer_sequencer_checker #(.WORD_W(WORD_W)) u_checker (
  .mclk(mclk), .rst_b(rst_b), .ce(ce), .masterClear(masterClear), .start(start),
  .accWord(accWord), .effAddr(effAddr), .memCmd(memCmd), .memAck(memAck),
  .memRdata(memRdata), .intrStrobe(intrStrobe), .intrPending(intrPending),
  .pcIncrement(pcIncrement), .countInhibit(countInhibit),
  .transferDoneLevel(transferDoneLevel), .lastIterationLevel(lastIterationLevel),
  .accStore(accStore), .accStoreData(accStoreData), .finished(finished), .busy(busy));
`default_nettype wire

// ==== block_transfer_mem_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module block_transfer_mem_model (
  input  wire logic                         mclk,
  input  wire logic                         rst_b,
  input  wire logic [3:0]                   waitCycles,
  input  wire block_transfer_pkg::mem_cmd_s memCmd,
  output logic                              memAck,
  output logic      [35:0]                  memRdata
);
  logic [35:0] mem [0:255];
  logic [3:0]  waitCnt_q;

  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = {28'hC0D_E5A5, i[7:0]};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read data toggles outside the ack cycle so a late sample never looks valid
  always @(posedge mclk)
  begin
    memRdata <= ~memRdata;
    if (!rst_b)
    begin
      memAck    <= 1'b0;
      waitCnt_q <= 4'h0;
      memRdata  <= 36'h0;
    end
    else if (memAck || !memCmd.req)
    begin
      memAck    <= 1'b0;
      waitCnt_q <= 4'h0;
    end
    else if (waitCnt_q == waitCycles)
    begin
      memAck   <= 1'b1;
      memRdata <= mem[memCmd.addr[7:0]];
      if (memCmd.write)
        mem[memCmd.addr[7:0]] <= memCmd.wdata;
    end
    else
      waitCnt_q <= waitCnt_q + 4'h1;
  end
endmodule // block_transfer_mem_model
`default_nettype wire

// ==== block_transfer_sequencer_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module block_transfer_sequencer_tb_top;
  logic                         mclk, rst_b, ce, masterClear, start, intrPending, memAck;
  logic                         intrStrobe, pcIncrement, countInhibit, transferDoneLevel;
  logic                         lastIterationLevel, accStore, finished, busy;
  logic [35:0]                  accWord, memRdata, accStoreData, storedPair;
  logic [17:0]                  effAddr;
  logic [3:0]                   memWait;
  block_transfer_pkg::mem_cmd_s memCmd;
  int                           fail_count, compares, cycles, nIntr, nPc, nStore;

  block_transfer_sequencer #(.WORD_W(36)) u_dut (
    .mclk(mclk), .rst_b(rst_b), .ce(ce), .masterClear(masterClear), .start(start),
    .accWord(accWord), .effAddr(effAddr), .memCmd(memCmd), .memAck(memAck),
    .memRdata(memRdata), .intrStrobe(intrStrobe), .intrPending(intrPending),
    .pcIncrement(pcIncrement), .countInhibit(countInhibit),
    .transferDoneLevel(transferDoneLevel), .lastIterationLevel(lastIterationLevel),
    .accStore(accStore), .accStoreData(accStoreData), .finished(finished), .busy(busy));

  block_transfer_mem_model u_mem (
    .mclk(mclk), .rst_b(rst_b), .waitCycles(memWait), .memCmd(memCmd),
    .memAck(memAck), .memRdata(memRdata));

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // pulses are counted mid-cycle so combinational outputs have settled
  always @(negedge mclk)
  begin
    if (rst_b && ce)
    begin
      if (intrStrobe === 1'b1) nIntr++;
      if (pcIncrement === 1'b1) nPc++;
      if (accStore === 1'b1)
      begin
        nStore++;
        storedPair = accStoreData;
      end
    end
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [35:0] pat(input logic [7:0] a);
    return {28'hC0D_E5A5, a};
  endfunction

  task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({35'h0, got}, {35'h0, exp});
  endtask

  task automatic chk_copy(input logic [7:0] s, input logic [7:0] d, input int n);
    for (int i = 0; i < n; i++)
      chk_word(u_mem.mem[d + i[7:0]], pat(s + i[7:0]));
  endtask

  task automatic run(input logic [17:0] s, input logic [17:0] d, input logic [17:0] e,
                     input logic [3:0] w, input logic pend);
    int n;
    nIntr  = 0;
    nPc    = 0;
    nStore = 0;
    @(posedge mclk);
    accWord   <= {s, d};
    effAddr   <= e;
    memWait   <= w;
    intrPending <= pend;
    start     <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    n = 0;
    while (finished !== 1'b1 && n < 3000)
    begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
    @(negedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // a refused start and a freeze land mid-transfer; the copy must be unaffected
  task automatic t_normal();
    fork
      run(18'h0_0010, 18'h0_0040, 18'h0_0043, 4'h0, 1'b0);
      begin
        repeat (8) @(posedge mclk);
        ce      <= 1'b0;
        start   <= 1'b1;
        accWord <= 36'h0;
        repeat (3) @(posedge mclk);
        ce <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
      end
    join
    chk_copy(8'h10, 8'h40, 4);
    chk_word(u_mem.mem[8'h44], pat(8'h44));
    chk_word(36'(nPc), 36'h1);
    chk_word(36'(nIntr), 36'h4);
    chk_word(36'(nStore), 36'h0);
    chk_bit(lastIterationLevel, 1'b1);
  endtask

  task automatic t_slow();
    run(18'h0_0018, 18'h0_0050, 18'h0_0050, 4'h3, 1'b0);
    chk_copy(8'h18, 8'h50, 1);
    chk_word(u_mem.mem[8'h51], pat(8'h51));
    chk_word(36'(nPc), 36'h1);
  endtask

  task automatic t_irq();
    run(18'h0_0020, 18'h0_0060, 18'h0_0067, 4'h1, 1'b1);
    chk_word(36'(nStore), 36'h1);
    chk_word(storedPair, 36'h0_0084_0061);
    chk_bit(lastIterationLevel, 1'b0);
    chk_bit(transferDoneLevel, 1'b1);
    chk_word(36'(nPc), 36'h0);
    chk_word(u_mem.mem[8'h61], pat(8'h61));
    run(storedPair[35:18], storedPair[17:0], 18'h0_0067, 4'h0, 1'b0);
    chk_copy(8'h20, 8'h60, 8);
    chk_word(36'(nPc), 36'h1);
  endtask

  task automatic t_clear();
    @(posedge mclk);
    accWord <= 36'h0_00C0_0080;
    effAddr <= 18'h0_008F;
    memWait <= 4'h2;
    start   <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    chk_bit(countInhibit, 1'b1);
    @(posedge mclk);
    masterClear <= 1'b1;
    @(posedge mclk);
    masterClear <= 1'b0;
    @(negedge mclk);
    chk_bit(busy, 1'b0);
    chk_bit(countInhibit, 1'b0);
    chk_word(u_mem.mem[8'h8F], pat(8'h8F));
    run(18'h0_0030, 18'h0_0080, 18'h0_0082, 4'h0, 1'b0);
    chk_copy(8'h30, 8'h80, 3);
    @(posedge mclk);
    masterClear <= 1'b1;
    @(posedge mclk);
    masterClear <= 1'b0;
    @(negedge mclk);
    chk_bit(transferDoneLevel, 1'b0);
    chk_bit(lastIterationLevel, 1'b0);
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    rst_b       = 1'b0;
    ce          = 1'b1;
    masterClear = 1'b0;
    start       = 1'b0;
    intrPending = 1'b0;
    accWord     = 36'h0;
    effAddr     = 18'h0;
    memWait     = 4'h0;
    fail_count  = 0;
    compares    = 0;
    cycles      = 0;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    t_normal();
    t_slow();
    t_irq();
    t_clear();
    tally_and_finish();
  end
endmodule // block_transfer_sequencer_tb_top
`default_nettype wire
